// >>> logic/opm_defines.svh
// Purpose: Constants of the operator panel menu controller.
// Assumes: 16-bit register port with byte offsets, 50 MHz core clock.
// Notes:   Types live in opm_pkg; this header holds numbers only.
// Behaviour
// - Plus in selection steps class D16,D32,X,Y,M,S,T,C cyclically.
// - Confirm in selection opens monitor screen of the selected class.
// - Back in selection returns to the time display screen.
// - Bit classes show 8 points for X or Y, 10 for M or S.
// - Plus or minus in bit monitor moves start number by ten.
// - Back in bit monitor returns to class selection.
// - Registered keyword leaves only time and error display items.
// - Confirm with keyword registered blinks error indication five seconds.
// - Force only Y,M,S; value change T,C,D; setting change T,C.
// - 32-bit indicator lit only while class D32 is selected on the selection screen.
// - Display refresh follows host scan writes of point and value data.
// - Value format follows the host decimal or hexadecimal setting.
// - Backlight goes off after host-set idle time.
// - Pressed state of each button is readable by host.
// - Host protection setting restricts operator setting functions.
// - Host selection enables or suppresses operation error display.
// - Host-designated device is shown without operator selection.
// - Bit force mode moves cursor with plus/minus, confirm inverts point.
// - Panel has exactly four buttons: back, minus, plus, confirm.
`ifndef OPM_DEFINES_SVH
`define OPM_DEFINES_SVH

`define OPM_CLK_HZ          50000000
`define OPM_DEBOUNCE_MS     10
`define OPM_ERR_BLINK_MS    5000
`define OPM_SEC_MS          1000

`define OPM_ADDR_W          8
`define OPM_DATA_W          16

`define OPM_OFS_CTRL        8'h00
`define OPM_OFS_BL_TIME     8'h04
`define OPM_OFS_BUTTONS     8'h08
`define OPM_OFS_STATUS      8'h0C
`define OPM_OFS_POINTS      8'h10
`define OPM_OFS_CUR_VAL     8'h14
`define OPM_OFS_REQ         8'h18
`define OPM_OFS_REQ_NUM     8'h1C
`define OPM_OFS_REQ_VAL     8'h20
`define OPM_OFS_DESIG       8'h24
`define OPM_OFS_ERR_CODE    8'h28
`define OPM_OFS_DEV_NUM     8'h2C

`define OPM_CTRL_KEYWORD    0
`define OPM_CTRL_HEX        1
`define OPM_CTRL_ERR_EN     2
`define OPM_CTRL_PROTECT    3
`define OPM_CTRL_DESIG      4
`define OPM_CTRL_W          5
`define OPM_CTRL_RST        5'h04

`define OPM_BL_TIME_RST     16'h0000

`define OPM_BTN_BACK        0
`define OPM_BTN_MINUS       1
`define OPM_BTN_PLUS        2
`define OPM_BTN_OK          3
`define OPM_BTN_COUNT       4

`define OPM_PTS_XY          4'h8
`define OPM_PTS_MS          4'hA
`define OPM_BIT_STEP        16'h000A
`define OPM_NUM_MAX         16'hFFFF

`endif

// >>> logic/opm_pkg.sv
// Purpose: Types of the operator panel menu controller.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Shared by the panel and its bench.
package opm_pkg;

  typedef enum logic [2:0] {
    OPM_SCR_TIME      = 3'b000,
    OPM_SCR_SELECT    = 3'b001,
    OPM_SCR_BIT_MON   = 3'b010,
    OPM_SCR_BIT_FORCE = 3'b011,
    OPM_SCR_WORD_MON  = 3'b100,
    OPM_SCR_EDIT_CUR  = 3'b101,
    OPM_SCR_EDIT_SET  = 3'b110,
    OPM_SCR_DESIG     = 3'b111
  } opm_screen_t;

  typedef enum logic [2:0] {
    OPM_CLS_D16 = 3'b000,
    OPM_CLS_D32 = 3'b001,
    OPM_CLS_X   = 3'b010,
    OPM_CLS_Y   = 3'b011,
    OPM_CLS_M   = 3'b100,
    OPM_CLS_S   = 3'b101,
    OPM_CLS_T   = 3'b110,
    OPM_CLS_C   = 3'b111
  } opm_class_t;

  typedef enum logic [1:0] {
    OPM_REQ_FORCE   = 2'b00,
    OPM_REQ_CUR_VAL = 2'b01,
    OPM_REQ_SET_VAL = 2'b10
  } opm_req_t;

endpackage

// >>> logic/opm_debounce.sv
// Purpose: Debounce one button and flag each press once.
// Assumes: Raw input is synchronous to the clock, high while pressed.
// Notes:   A level change is accepted only after it holds steady.
`timescale 1ns/100ps
module opm_debounce #(
  parameter int unsigned STABLE_CYCLES = 500000
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Button
  input  wire logic i_raw,
  output logic      o_level,
  output logic      o_press
);

  localparam int unsigned CNT_W = $clog2(STABLE_CYCLES + 1);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_level <= 1'b0;
      o_press <= 1'b0;
    end else begin
      o_press <= 1'b0;
      if (i_raw == o_level) begin
        cnt_reg <= '0;
      end else if (cnt_reg == CNT_W'(STABLE_CYCLES - 1)) begin
        cnt_reg <= '0;
        o_level <= i_raw;
        o_press <= i_raw;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// >>> logic/opm_panel.sv
// Purpose: Four-button operator panel menu with host program controls.
// Assumes: Host reaches registers over a plain strobe port each scan.
// Notes:   Display content is shown as registered fields, not segments.
`timescale 1ns/100ps
`include "opm_defines.svh"
module opm_panel
  import opm_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES =
    `OPM_DEBOUNCE_MS * (`OPM_CLK_HZ / 1000),
  parameter int unsigned ERR_BLINK_CYCLES =
    `OPM_ERR_BLINK_MS * (`OPM_CLK_HZ / 1000),
  parameter int unsigned SEC_CYCLES =
    `OPM_SEC_MS * (`OPM_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  // Buttons, high while pressed
  input  wire logic                   i_btn_back,
  input  wire logic                   i_btn_minus,
  input  wire logic                   i_btn_plus,
  input  wire logic                   i_btn_ok,
  // Register port
  input  wire logic [`OPM_ADDR_W-1:0] i_addr,
  input  wire logic [`OPM_DATA_W-1:0] i_wr_data,
  input  wire logic                   i_wr_en,
  input  wire logic                   i_rd_en,
  output logic      [`OPM_DATA_W-1:0] o_rd_data,
  // Display
  output logic      [2:0]             o_screen,
  output logic      [2:0]             o_class,
  output logic      [15:0]            o_dev_num,
  output logic      [9:0]             o_points,
  output logic      [3:0]             o_cursor,
  output logic      [15:0]            o_value,
  output logic                        o_ind_32bit,
  output logic                        o_hex_fmt,
  output logic                        o_backlight,
  output logic                        o_err_blink,
  output logic                        o_err_show,
  output logic                        o_req_pending
);

  localparam int unsigned BLINK_W = $clog2(ERR_BLINK_CYCLES + 1);
  localparam int unsigned SEC_W   = $clog2(SEC_CYCLES + 1);

  logic [`OPM_BTN_COUNT-1:0] btn_raw;
  logic [`OPM_BTN_COUNT-1:0] btn_lvl;
  logic [`OPM_BTN_COUNT-1:0] btn_press;

  opm_screen_t               screen_reg;
  opm_class_t                class_reg;
  logic [15:0]               dev_num_reg;
  logic [3:0]                cursor_reg;
  logic [15:0]               edit_val_reg;
  logic                      edited_reg;

  logic [`OPM_CTRL_W-1:0]    ctrl_reg;
  logic [15:0]               bl_time_reg;
  logic [9:0]                points_reg;
  logic [15:0]               cur_val_reg;
  logic [15:0]               desig_reg;
  logic [15:0]               err_code_reg;

  logic                      req_pend_reg;
  opm_req_t                  req_kind_reg;
  opm_class_t                req_class_reg;
  logic [3:0]                req_point_reg;
  logic [15:0]               req_num_reg;
  logic [15:0]               req_val_reg;

  logic [BLINK_W-1:0]        blink_cnt_reg;
  logic [SEC_W-1:0]          sec_cnt_reg;
  logic [15:0]               idle_sec_reg;

  logic                      kw;
  logic                      prot;
  logic                      p_back;
  logic                      p_minus;
  logic                      p_plus;
  logic                      p_ok;
  logic                      is_bit;
  logic                      can_force;
  logic                      is_tc;
  logic [3:0]                npts;
  logic                      force_req;
  logic                      commit_cur;
  logic                      commit_set;
  logic                      req_read;
  logic                      kw_ok;
  logic                      bl_on;

  assign btn_raw[`OPM_BTN_BACK]  = i_btn_back;
  assign btn_raw[`OPM_BTN_MINUS] = i_btn_minus;
  assign btn_raw[`OPM_BTN_PLUS]  = i_btn_plus;
  assign btn_raw[`OPM_BTN_OK]    = i_btn_ok;

  for (genvar b = 0; b < `OPM_BTN_COUNT; b++) begin : g_btn
    opm_debounce #(
      .STABLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_deb (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_raw      (btn_raw[b]),
      .o_level    (btn_lvl[b]),
      .o_press    (btn_press[b])
    );
  end

  always_comb begin
    kw        = ctrl_reg[`OPM_CTRL_KEYWORD];
    prot      = ctrl_reg[`OPM_CTRL_PROTECT];
    p_back    = btn_press[`OPM_BTN_BACK];
    p_minus   = btn_press[`OPM_BTN_MINUS];
    p_plus    = btn_press[`OPM_BTN_PLUS];
    p_ok      = btn_press[`OPM_BTN_OK];
    is_bit    = (class_reg inside {OPM_CLS_X, OPM_CLS_Y,
                                   OPM_CLS_M, OPM_CLS_S});
    can_force = (class_reg inside {OPM_CLS_Y, OPM_CLS_M,
                                   OPM_CLS_S});
    is_tc     = (class_reg inside {OPM_CLS_T, OPM_CLS_C});
    npts      = (class_reg inside {OPM_CLS_X, OPM_CLS_Y}) ?
                `OPM_PTS_XY : `OPM_PTS_MS;
    force_req = (screen_reg == OPM_SCR_BIT_FORCE) && p_ok;
    commit_cur = (screen_reg == OPM_SCR_EDIT_CUR) && p_ok &&
                 !(is_tc && !edited_reg);
    commit_set = (screen_reg == OPM_SCR_EDIT_SET) && p_ok;
    req_read  = i_rd_en && (i_addr == `OPM_OFS_REQ);
    kw_ok     = kw && p_ok;
    bl_on     = (bl_time_reg == 16'h0000) ||
                (idle_sec_reg < bl_time_reg);
  end

  // Menu navigation. A keyword registered by the host pulls every screen
  // back to the time display, so no hidden item stays reachable.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      screen_reg   <= OPM_SCR_TIME;
      class_reg    <= OPM_CLS_D16;
      dev_num_reg  <= 16'h0000;
      cursor_reg   <= 4'h0;
      edit_val_reg <= 16'h0000;
      edited_reg   <= 1'b0;
    end else if (kw) begin
      screen_reg <= OPM_SCR_TIME;
    end else begin
      unique case (screen_reg)
        OPM_SCR_TIME: begin
          if (ctrl_reg[`OPM_CTRL_DESIG]) begin
            screen_reg <= OPM_SCR_DESIG;
          end else if (p_ok) begin
            screen_reg <= OPM_SCR_SELECT;
          end
        end
        OPM_SCR_DESIG: begin
          if (!ctrl_reg[`OPM_CTRL_DESIG]) begin
            screen_reg <= OPM_SCR_TIME;
          end
        end
        OPM_SCR_SELECT: begin
          if (p_plus) begin
            class_reg <= opm_class_t'(class_reg + 3'h1);
          end else if (p_minus) begin
            class_reg <= opm_class_t'(class_reg - 3'h1);
          end else if (p_back) begin
            screen_reg <= OPM_SCR_TIME;
          end else if (p_ok) begin
            dev_num_reg <= 16'h0000;
            cursor_reg  <= 4'h0;
            screen_reg  <= is_bit ? OPM_SCR_BIT_MON : OPM_SCR_WORD_MON;
          end
        end
        OPM_SCR_BIT_MON: begin
          if (p_plus) begin
            if (dev_num_reg <= `OPM_NUM_MAX - `OPM_BIT_STEP) begin
              dev_num_reg <= dev_num_reg + `OPM_BIT_STEP;
            end
          end else if (p_minus) begin
            dev_num_reg <= (dev_num_reg >= `OPM_BIT_STEP) ?
                           dev_num_reg - `OPM_BIT_STEP : 16'h0000;
          end else if (p_back) begin
            screen_reg <= OPM_SCR_SELECT;
          end else if (p_ok && can_force && !prot) begin
            cursor_reg <= 4'h0;
            screen_reg <= OPM_SCR_BIT_FORCE;
          end
        end
        OPM_SCR_BIT_FORCE: begin
          if (p_plus && (cursor_reg < npts - 4'h1)) begin
            cursor_reg <= cursor_reg + 4'h1;
          end else if (p_minus && (cursor_reg != 4'h0)) begin
            cursor_reg <= cursor_reg - 4'h1;
          end else if (p_back) begin
            screen_reg <= OPM_SCR_SELECT;
          end
        end
        OPM_SCR_WORD_MON: begin
          if (p_plus) begin
            dev_num_reg <= dev_num_reg +
                           ((class_reg == OPM_CLS_D32) ? 16'h0002 : 16'h0001);
          end else if (p_minus) begin
            dev_num_reg <= (dev_num_reg != 16'h0000) ?
                           dev_num_reg - 16'h0001 : 16'h0000;
          end else if (p_back) begin
            screen_reg <= OPM_SCR_SELECT;
          end else if (p_ok && !prot) begin
            edit_val_reg <= cur_val_reg;
            edited_reg   <= 1'b0;
            screen_reg   <= OPM_SCR_EDIT_CUR;
          end
        end
        OPM_SCR_EDIT_CUR, OPM_SCR_EDIT_SET: begin
          if (p_plus) begin
            edit_val_reg <= edit_val_reg + 16'h0001;
            edited_reg   <= 1'b1;
          end else if (p_minus) begin
            edit_val_reg <= edit_val_reg - 16'h0001;
            edited_reg   <= 1'b1;
          end else if (p_back) begin
            screen_reg <= OPM_SCR_WORD_MON;
          end else if (p_ok) begin
            // Confirm before any change on a timer or counter moves on
            // to the setting value instead of committing.
            if (screen_reg == OPM_SCR_EDIT_CUR && is_tc && !edited_reg) begin
              screen_reg <= OPM_SCR_EDIT_SET;
            end else begin
              screen_reg <= OPM_SCR_WORD_MON;
            end
          end
        end
      endcase
    end
  end

  // Host-side registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_reg     <= `OPM_CTRL_RST;
      bl_time_reg  <= `OPM_BL_TIME_RST;
      points_reg   <= 10'h000;
      cur_val_reg  <= 16'h0000;
      desig_reg    <= 16'h0000;
      err_code_reg <= 16'h0000;
    end else if (i_wr_en) begin
      unique case (i_addr)
        `OPM_OFS_CTRL:     ctrl_reg     <= i_wr_data[`OPM_CTRL_W-1:0];
        `OPM_OFS_BL_TIME:  bl_time_reg  <= i_wr_data;
        `OPM_OFS_POINTS:   points_reg   <= i_wr_data[9:0];
        `OPM_OFS_CUR_VAL:  cur_val_reg  <= i_wr_data;
        `OPM_OFS_DESIG:    desig_reg    <= i_wr_data;
        `OPM_OFS_ERR_CODE: err_code_reg <= i_wr_data;
        default: ;
      endcase
    end
  end

  // Pending request for the host to apply at its end of scan. A new
  // request in the same cycle as the clearing read wins.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      req_pend_reg  <= 1'b0;
      req_kind_reg  <= OPM_REQ_FORCE;
      req_class_reg <= OPM_CLS_D16;
      req_point_reg <= 4'h0;
      req_num_reg   <= 16'h0000;
      req_val_reg   <= 16'h0000;
    end else if (!kw && (force_req || commit_cur || commit_set)) begin
      req_pend_reg  <= 1'b1;
      req_kind_reg  <= force_req  ? OPM_REQ_FORCE :
                       commit_set ? OPM_REQ_SET_VAL : OPM_REQ_CUR_VAL;
      req_class_reg <= class_reg;
      req_point_reg <= cursor_reg;
      req_num_reg   <= dev_num_reg;
      req_val_reg   <= force_req ?
                       {15'h0000, ~points_reg[cursor_reg]} :
                       edit_val_reg;
    end else if (req_read) begin
      req_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      blink_cnt_reg <= '0;
    end else if (kw_ok) begin
      blink_cnt_reg <= BLINK_W'(ERR_BLINK_CYCLES);
    end else if (blink_cnt_reg != '0) begin
      blink_cnt_reg <= blink_cnt_reg - 1'b1;
    end
  end

  // Idle time counts whole seconds since the last press; it saturates so
  // a long idle never wraps round and lights the panel again.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sec_cnt_reg  <= '0;
      idle_sec_reg <= 16'h0000;
    end else if (btn_press != '0) begin
      sec_cnt_reg  <= '0;
      idle_sec_reg <= 16'h0000;
    end else if (sec_cnt_reg == SEC_W'(SEC_CYCLES - 1)) begin
      sec_cnt_reg <= '0;
      if (idle_sec_reg != `OPM_NUM_MAX) begin
        idle_sec_reg <= idle_sec_reg + 16'h0001;
      end
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_en) begin
      unique case (i_addr)
        `OPM_OFS_CTRL:     o_rd_data <= {11'h000, ctrl_reg};
        `OPM_OFS_BL_TIME:  o_rd_data <= bl_time_reg;
        `OPM_OFS_BUTTONS:  o_rd_data <= {12'h000, btn_lvl};
        `OPM_OFS_STATUS:   o_rd_data <= {1'b0, edited_reg,
                                         (blink_cnt_reg != '0), bl_on,
                                         cursor_reg, 1'b0, class_reg,
                                         1'b0, screen_reg};
        `OPM_OFS_POINTS:   o_rd_data <= {6'h00, points_reg};
        `OPM_OFS_CUR_VAL:  o_rd_data <= cur_val_reg;
        `OPM_OFS_REQ:      o_rd_data <= {req_pend_reg, req_kind_reg,
                                         req_class_reg, 6'h00,
                                         req_point_reg};
        `OPM_OFS_REQ_NUM:  o_rd_data <= req_num_reg;
        `OPM_OFS_REQ_VAL:  o_rd_data <= req_val_reg;
        `OPM_OFS_DESIG:    o_rd_data <= desig_reg;
        `OPM_OFS_ERR_CODE: o_rd_data <= err_code_reg;
        `OPM_OFS_DEV_NUM:  o_rd_data <= dev_num_reg;
        default:           o_rd_data <= 16'h0000;
      endcase
    end else begin
      o_rd_data <= 16'h0000;
    end
  end

  // Display outputs, all registered one cycle behind the state.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_screen      <= 3'h0;
      o_class       <= 3'h0;
      o_dev_num     <= 16'h0000;
      o_points      <= 10'h000;
      o_cursor      <= 4'h0;
      o_value       <= 16'h0000;
      o_ind_32bit   <= 1'b0;
      o_hex_fmt     <= 1'b0;
      o_backlight   <= 1'b1;
      o_err_blink   <= 1'b0;
      o_err_show    <= 1'b0;
      o_req_pending <= 1'b0;
    end else begin
      o_screen  <= screen_reg;
      if (screen_reg == OPM_SCR_DESIG) begin
        o_class   <= desig_reg[2:0];
        o_dev_num <= {4'h0, desig_reg[15:4]};
      end else begin
        o_class   <= class_reg;
        o_dev_num <= dev_num_reg;
      end
      o_points  <= (npts == `OPM_PTS_XY) ?
                   {2'b00, points_reg[7:0]} : points_reg;
      o_cursor  <= cursor_reg;
      o_value   <= (screen_reg inside {OPM_SCR_EDIT_CUR, OPM_SCR_EDIT_SET}) ?
                   edit_val_reg : cur_val_reg;
      o_ind_32bit <= (screen_reg == OPM_SCR_SELECT) &&
                     (class_reg == OPM_CLS_D32);
      o_hex_fmt   <= ctrl_reg[`OPM_CTRL_HEX] && !is_bit;
      o_backlight <= bl_on;
      o_err_blink <= (blink_cnt_reg != '0);
      o_err_show  <= ctrl_reg[`OPM_CTRL_ERR_EN] &&
                     (err_code_reg != 16'h0000);
      o_req_pending <= req_pend_reg;
    end
  end

endmodule

// >>> verification/opm_panel_monitor.sv
// Purpose: Concurrent checks on the panel ports.
// Assumes: Small debounce and blink counts in the bench.
// Notes:   Sees only the top module ports.
`timescale 1ns/100ps
module opm_panel_monitor (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_rd_en,
  input wire logic [15:0] o_rd_data,
  input wire logic [2:0]  o_screen,
  input wire logic [2:0]  o_class,
  input wire logic [15:0] o_dev_num,
  input wire logic [9:0]  o_points,
  input wire logic [3:0]  o_cursor,
  input wire logic        o_ind_32bit,
  input wire logic        o_hex_fmt,
  input wire logic        o_err_blink
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_RD_IDLE: assert property (!$past(i_rd_en) |-> o_rd_data == 16'h0000)
    else $error("read data outside read cycle");
  AST_IND32: assert property (o_ind_32bit |-> o_screen == 3'h1 && o_class == 3'h1)
    else $error("wide indicator lit wrongly");
  AST_PTS_XY: assert property (o_screen == 3'h2 && o_class inside {3'h2, 3'h3}
    |-> o_points[9:8] == 2'b00) else $error("extra points shown");
  AST_BIT_STEP: assert property (o_screen == 3'h2 && $stable(o_screen)
    && o_dev_num != $past(o_dev_num) |-> o_dev_num == 16'h0000
    || o_dev_num == $past(o_dev_num) + 16'h000A
    || o_dev_num == $past(o_dev_num) - 16'h000A) else $error("bad step");
  AST_HEX: assert property (o_hex_fmt |-> o_class inside {0, 1, 6, 7})
    else $error("hex on bit class");
  AST_FORCE_CLS: assert property (o_screen == 3'h3 |-> o_class inside {3, 4, 5})
    else $error("force on wrong class");
  AST_SEL_ORDER: assert property (o_screen == 3'h1 && $past(o_screen) == 3'h1
    && o_class != $past(o_class) |-> o_class == $past(o_class) + 3'd1
    || o_class == $past(o_class) - 3'd1) else $error("class order");
  AST_BLINK_LEN: assert property ($rose(o_err_blink) |-> o_err_blink [*8])
    else $error("blink too short");
  AST_CURSOR: assert property (o_screen == 3'h3
    |-> o_cursor < ((o_class == 3'h3) ? 4'd8 : 4'd10)) else $error("cursor range");
endmodule
bind opm_panel opm_panel_monitor u_mon (.*);

// >>> verification/opm_host_model.sv
// Purpose: Host program model on the panel register port.
// Assumes: Read data stands in the cycle after the strobe.
// Notes:   A scan applies a pending force once and refreshes points.
`timescale 1ns/100ps
`include "opm_defines.svh"
module opm_host_model (
  // Clock
  input  wire logic        i_core_clk,
  // Register port
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wr_data,
  output logic             o_wr_en,
  output logic             o_rd_en,
  input  wire logic [15:0] i_rd_data
);
  logic [15:0] pts;
  initial begin
    o_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    pts = 16'h0000;
  end
  // Only the host program sets hex format and other controls.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wr_data <= d;
    o_wr_en <= 1'b1;
    @(posedge i_core_clk);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
    if (a == `OPM_OFS_POINTS) pts = d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_core_clk);
    o_rd_en <= 1'b0;
    @(posedge i_core_clk);
    d = i_rd_data;
  endtask
  // End of scan: a force is applied exactly once, then points refresh.
  task automatic scan(output logic [15:0] req);
    logic [15:0] v;
    rd(`OPM_OFS_REQ, req);
    if (req[15] && req[14:13] == 2'b00) begin
      rd(`OPM_OFS_REQ_VAL, v);
      pts[req[3:0]] = v[0];
      wr(`OPM_OFS_POINTS, pts);
    end
  endtask
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench of the operator panel.
// Assumes: Short debounce, second and blink counts.
// Notes:   Buttons pressed with raw levels held past debounce.
`timescale 1ns/100ps
`include "opm_defines.svh"
module testbench;
  import opm_pkg::*;
  localparam int DB = 4;
  logic        clk, rst_n, ind, bl, blk, hexf, errs, rqp;
  logic [3:0]  btn, cur;
  logic [7:0]  addr;
  logic [15:0] wd, rdat, r, p, dev, val;
  logic        we, re;
  logic [2:0]  scr, cls;
  logic [9:0]  pts;
  int          error_cnt, n_tests, i, seed;
  opm_host_model u_host (.i_core_clk(clk), .o_addr(addr), .o_wr_data(wd),
    .o_wr_en(we), .o_rd_en(re), .i_rd_data(rdat));
  opm_panel #(.DEBOUNCE_CYCLES(DB), .ERR_BLINK_CYCLES(50), .SEC_CYCLES(20))
  u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_btn_back(btn[0]),
    .i_btn_minus(btn[1]), .i_btn_plus(btn[2]), .i_btn_ok(btn[3]),
    .i_addr(addr), .i_wr_data(wd), .i_wr_en(we), .i_rd_en(re),
    .o_rd_data(rdat), .o_screen(scr), .o_class(cls), .o_dev_num(dev),
    .o_points(pts), .o_cursor(cur), .o_value(val), .o_ind_32bit(ind),
    .o_hex_fmt(hexf), .o_backlight(bl), .o_err_blink(blk),
    .o_err_show(errs), .o_req_pending(rqp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] exp_pts(logic [2:0] c, logic [15:0] v);
    return (c == OPM_CLS_X || c == OPM_CLS_Y) ? {8'h00, v[7:0]} : v & 16'h03FF;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic press(int b);
    @(posedge clk) btn[b] <= 1'b1;
    repeat (DB + 3) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (DB + 4) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    seed = 32'h3c065b27;
    btn = 4'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    u_host.rd(`OPM_OFS_CTRL, r);
    chk("ctrl", 16'h0004, r);
    u_host.rd(8'h30, r);
    chk("unmapped", 16'h0000, r);
    press(3);
    for (i = 0; i < 8; i++) begin
      chk("class", i, cls);
      chk("ind32", i == 1, ind);
      press(2);
    end
    press(0);
    chk("screen", 0, scr);
    $display("test select done");
    press(3);
    repeat (3) press(2);
    p = $random(seed);
    u_host.wr(`OPM_OFS_POINTS, p);
    press(3);
    chk("screen", 2, scr);
    chk("points", exp_pts(3, p), pts);
    press(2);
    chk("devnum", 16'h000A, dev);
    press(1);
    chk("devnum", 16'h0000, dev);
    press(3);
    press(2);
    chk("cursor", 1, cur);
    press(3);
    u_host.scan(r);
    chk("request", 16'h8C01, r);
    repeat (3) @(posedge clk);
    chk("points", exp_pts(3, p ^ 16'h0002), pts);
    press(0);
    press(1);
    press(3);
    press(3);
    chk("screen", 2, scr);
    press(0);
    chk("screen", 1, scr);
    press(0);
    $display("test bit screens done");
    u_host.wr(`OPM_OFS_CTRL, 16'h0005);
    press(3);
    chk("screen", 0, scr);
    chk("blink", 1, blk);
    press(3);
    repeat (30) @(posedge clk);
    chk("blink", 1, blk);
    repeat (15) @(posedge clk);
    chk("blink", 0, blk);
    $display("test keyword done");
    for (i = 0; i < 4; i++) begin
      p = $random(seed) & 16'h000F;
      btn <= p[3:0];
      repeat (DB + 3) @(posedge clk);
      u_host.rd(`OPM_OFS_BUTTONS, r);
      chk("buttons", p, r);
      btn <= 4'h0;
      repeat (DB + 3) @(posedge clk);
    end
    u_host.wr(`OPM_OFS_BL_TIME, 16'h0001);
    repeat (45) @(posedge clk);
    chk("backlight", 0, bl);
    press(1);
    chk("backlight", 1, bl);
    $display("test host controls done");
    u_host.wr(`OPM_OFS_ERR_CODE, 16'h0007);
    repeat (2) @(posedge clk);
    chk("errshow", 1, errs);
    u_host.wr(`OPM_OFS_CTRL, 16'h000A);
    u_host.wr(`OPM_OFS_CUR_VAL, 16'h1234);
    press(3);
    chk("errshow", 0, errs);
    repeat (4) press(2);
    chk("hex", 1, hexf);
    press(3);
    press(3);
    chk("screen", 4, scr);
    chk("value", 16'h1234, val);
    u_host.wr(`OPM_OFS_CTRL, 16'h0002);
    press(3);
    press(2);
    chk("value", 16'h1235, val);
    press(3);
    chk("pending", 1, rqp);
    u_host.scan(r);
    chk("request", 16'hB800, r);
    u_host.rd(`OPM_OFS_REQ_VAL, r);
    chk("reqval", 16'h1235, r);
    press(3);
    press(3);
    chk("screen", 6, scr);
    press(1);
    press(3);
    u_host.scan(r);
    chk("request", 16'hD800, r);
    press(0);
    press(0);
    u_host.wr(`OPM_OFS_DESIG, 16'h0125);
    u_host.wr(`OPM_OFS_CTRL, 16'h0010);
    repeat (3) @(posedge clk);
    chk("screen", 7, scr);
    chk("class", 5, cls);
    chk("devnum", 16'h0012, dev);
    $display("test word and designated done");
    print_verdict;
  end
endmodule
